/* File: design/lspm_ctrl.sv */
// lspm_ctrl: operating mode, pwm generator, watchdog and fail-safe logic
`timescale 1ns/10ps

// Summary of operation
// R1: wake from reset, rouse or qualified inputs
// R2: fail on enabled supply loss or watchdog
// R3: fault on any protection flag, overvoltage only with shutdown on
// R4: mode from wake, fail, fault
// R5: fault mode keeps faulted outputs off, autoretry
// R6: sleep default, config reads as zero
// R7: normal indicator one only in normal
// R8: normal on command, direct or pwm
// R9: rearm command from input or on bit
// R10: pwm period is 128 selected clocks
// R11: high time (n+1)/128, full code on
// R12: other direct inputs ignored under pwm
// R13: per output delay 16 times code
// R14: external clock loss stops pwm, flag
// R15: calibration low pulse sets oscillator period
// R16: out-of-window pulse ignored, keep or default
// R17: watchdog armed on rising wake sources
// R18: host toggles d15, timeout from oscillator
// R19: timeout or supply loss enters fail-safe
// R20: fail-safe outputs follow direct inputs
// R21: watchdog input bit returns to normal
// R22: grounded select leaves watchdog fail-safe
// R23: inputs synchronised and filtered high
module lspm_ctrl (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic pwm_ext_clk,
  input wire logic [3:0] direct_in,
  input wire logic reset_bar_pin,
  input wire logic rouse_pin,
  input wire logic failsafe_select_pin,
  input wire logic chip_sel_n,
  input wire logic logic_supply_fail,
  input wire logic logic_supply_loss_enable,
  input wire logic [3:0] current_limit_flags,
  input wire logic [3:0] thermal_flags,
  input wire logic [3:0] hard_short_flags,
  input wire logic supply_low_flag,
  input wire logic supply_excess_flag,
  input wire logic supply_excess_shutdown_off,
  input wire logic [3:0] on_bits,
  input wire logic [27:0] duty_codes,
  input wire logic [11:0] delay_codes,
  input wire logic [3:0] parallel_input_block,
  input wire logic pulse_module_enable,
  input wire logic pwm_clock_source_choice,
  input wire logic cal_arm,
  input wire logic spi_word_strobe,
  input wire logic watchdog_toggle_bit,
  input wire logic watchdog_input_bit,
  output logic [3:0] high_side_output,
  output logic [3:0] fault_rearm_command,
  output logic [3:0] fault_clear,
  output logic normal_mode_indicator,
  output logic external_clock_loss_flag,
  output logic [3:0] mode_state,
  output logic [15:0] osc_half_period
);

  // ----------------------------------------
  // input synchronisers, three stages
  // ----------------------------------------
  logic [7:0] pin_s1_r;  // first stage, read by second only
  logic [7:0] pin_s2_r;
  logic [7:0] pin_s3_r;
  logic [7:0] pin_stable_r;  // changes once stages two and three agree
  wire [7:0] pin_raw = {chip_sel_n, failsafe_select_pin, rouse_pin, reset_bar_pin, direct_in};

  // three flop chain, stable copy updates when last two agree
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pin_s1_r <= 8'h00;
      pin_s2_r <= 8'h00;
      pin_s3_r <= 8'h80;
      pin_stable_r <= 8'h80;
    end else if (clk_en) begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_stable_r <= (pin_s2_r & pin_s3_r) | (pin_stable_r & (pin_s2_r | pin_s3_r));
    end
  end

  wire [3:0] din_s = pin_stable_r[3:0];
  wire rst_pin_s = pin_stable_r[4];
  wire rouse_s = pin_stable_r[5];
  wire fsi_open_s = pin_stable_r[6];
  wire cs_n_s = pin_stable_r[7];

  // ----------------------------------------
  // input qualification filter
  // ----------------------------------------
  logic [3:0] in_active_r;  // input_active_qualified
  logic [7:0] qual_cnt_r [4];

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_qual
      // R23: require stable high
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          qual_cnt_r[gi] <= 8'h00;
          in_active_r[gi] <= 1'b0;
        end else if (clk_en) begin
          if (!din_s[gi]) begin
            qual_cnt_r[gi] <= 8'h00;
            in_active_r[gi] <= 1'b0;
          end else if (qual_cnt_r[gi] >= 8'(lspm_pkg::QUAL_CYC)) begin
            in_active_r[gi] <= 1'b1;
          end else begin
            qual_cnt_r[gi] <= qual_cnt_r[gi] + 8'h01;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // wake, fail, fault terms
  // ----------------------------------------
  // R1: wake sources
  wire wake = rst_pin_s | rouse_s | (|in_active_r);
  wire [3:0] out_fault = current_limit_flags | thermal_flags | hard_short_flags;
  // R3: fault term, overvoltage gated
  wire fault = (|out_fault) | supply_low_flag | (supply_excess_flag & ~supply_excess_shutdown_off);
  wire supply_fail = logic_supply_fail & logic_supply_loss_enable;

  logic wdog_armed_r;
  logic wdog_to_r;  // latched timeout, ends with rearm or grounded select
  logic supply_fs_r;  // fail-safe held from supply loss
  // R2: fail term
  wire fail = supply_fs_r | (wdog_to_r & fsi_open_s);

  // R4: mode decode
  function automatic lspm_pkg::lspm_mode_t lspm_mode_f(input logic w, input logic fl, input logic ft);
    if (!w) begin
      return lspm_pkg::LSPM_SLEEP;
    end else if (ft) begin
      return lspm_pkg::LSPM_FAULT;
    end else if (fl) begin
      return lspm_pkg::LSPM_FSAFE;
    end
    return lspm_pkg::LSPM_NORMAL;
  endfunction : lspm_mode_f

  lspm_pkg::lspm_mode_t mode_r;
  wire lspm_pkg::lspm_mode_t mode_nxt = lspm_mode_f(wake, fail, fault);
  wire sleep_m = (mode_r == lspm_pkg::LSPM_SLEEP);
  wire fsafe_m = (mode_r == lspm_pkg::LSPM_FSAFE);
  wire normal_m = (mode_r == lspm_pkg::LSPM_NORMAL);

  // R6: settings read as zero in sleep; R20: defaults in fail-safe
  wire cfg_ok = ~sleep_m & ~fail;
  wire [3:0] on_eff = cfg_ok ? on_bits : 4'h0;
  wire [3:0] blk_eff = cfg_ok ? parallel_input_block : 4'h0;
  wire pwm_en_eff = cfg_ok & pulse_module_enable;
  wire src_int = cfg_ok & pwm_clock_source_choice;

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  logic [5:0] wake_prev_r;
  logic wd_prev_r;
  logic [15:0] wdog_cnt_r;  // oscillator periods since last toggle
  wire [5:0] wake_src = {rst_pin_s, rouse_s, in_active_r};
  // R17: rising wake source arms watchdog
  wire wake_rise = |(wake_src & ~wake_prev_r);
  wire wd_toggled = spi_word_strobe & (watchdog_toggle_bit != wd_prev_r);
  // R21: watchdog input bit leaves fail-safe, other bits ignored
  wire rearm = spi_word_strobe & watchdog_input_bit & ~logic_supply_fail;
  logic osc_tick;  // one pulse per internal oscillator period

  // watchdog arming, counting and timeout latch
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wake_prev_r <= 6'h00;
      wd_prev_r <= 1'b0;
      wdog_armed_r <= 1'b0;
      wdog_cnt_r <= 16'h0000;
      wdog_to_r <= 1'b0;
      supply_fs_r <= 1'b0;
    end else if (clk_en) begin
      wake_prev_r <= wake_src;
      if (spi_word_strobe) begin
        wd_prev_r <= watchdog_toggle_bit;
      end
      // R17: grounded select disables the watchdog
      if (!fsi_open_s) begin
        wdog_armed_r <= 1'b0;
      end else if (wake_rise) begin
        wdog_armed_r <= 1'b1;
      end
      // R18: timeout counted in oscillator periods
      if (wd_toggled | ~wdog_armed_r | wdog_to_r) begin
        wdog_cnt_r <= 16'h0000;
      end else if (osc_tick) begin
        wdog_cnt_r <= wdog_cnt_r + 16'h0001;
      end
      // R19: timeout latches until rearm; R22: grounded select exits
      if (wdog_armed_r & fsi_open_s & (wdog_cnt_r >= lspm_pkg::WDOG_OSC_PER)) begin
        wdog_to_r <= 1'b1;
      end else if (rearm | ~fsi_open_s) begin
        wdog_to_r <= 1'b0;
      end
      // R19: supply loss holds fail-safe until rearm with supply good
      if (supply_fail) begin
        supply_fs_r <= 1'b1;
      end else if (rearm) begin
        supply_fs_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // internal oscillator and calibration
  // ----------------------------------------
  logic [15:0] osc_half_r;
  logic [15:0] osc_cnt_r;
  logic osc_clk_r;
  logic cal_wait_r;
  logic cal_run_r;
  logic [23:0] cal_cnt_r;
  logic cs_prev_r;
  wire cs_fall = cs_prev_r & ~cs_n_s;
  wire cs_rise = ~cs_prev_r & cs_n_s;
  // R16: pulse window check
  wire cal_in_win = (cal_cnt_r >= lspm_pkg::CAL_MIN_CYC) & (cal_cnt_r <= lspm_pkg::CAL_MAX_CYC);
  // R15: a phase lasts exactly half cycles, so a full period is the pulse over 128
  wire osc_wrap = (osc_cnt_r + 16'h0001 >= osc_half_r);
  assign osc_tick = osc_wrap & osc_clk_r;

  // free running oscillator with calibratable half period
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      osc_half_r <= lspm_pkg::OSC_HALF_DEF;
      osc_cnt_r <= 16'h0000;
      osc_clk_r <= 1'b0;
      cal_wait_r <= 1'b0;
      cal_run_r <= 1'b0;
      cal_cnt_r <= 24'h000000;
      cs_prev_r <= 1'b1;
    end else if (clk_en) begin
      cs_prev_r <= cs_n_s;
      if (osc_wrap) begin
        osc_cnt_r <= 16'h0000;
        osc_clk_r <= ~osc_clk_r;
      end else begin
        osc_cnt_r <= osc_cnt_r + 16'h0001;
      end
      // R15: armed by the trim command, next low pulse measured
      if (cal_arm) begin
        cal_wait_r <= 1'b1;
      end else if (cal_wait_r & cs_fall) begin
        cal_wait_r <= 1'b0;
        cal_run_r <= 1'b1;
        cal_cnt_r <= 24'h000000;
      end else if (cal_run_r & ~cs_rise & (cal_cnt_r != 24'hffffff)) begin
        cal_cnt_r <= cal_cnt_r + 24'h000001;
      end
      // R15: period is pulse length over 128, half of that per phase
      if (cal_run_r & cs_rise) begin
        cal_run_r <= 1'b0;
        // R16: out of window keeps the present setting
        if (cal_in_win) begin
          osc_half_r <= cal_cnt_r[23:8];
        end
      end
    end
  end

  // ----------------------------------------
  // pwm_ext_clk domain, its logic drives nothing (the pwm external clock is direct input 0)
  // ----------------------------------------
  // internal source crosses as a level, sampled in the pwm domain
  logic [1:0] ext_dom_sync_r;
  logic [6:0] ext_phase_r;
  logic ext_wrap_tgl_r;
  logic [2:0] ext_cfg_s1_r;
  logic [2:0] ext_cfg_s2_r;

  // 128 step counter on pwm_ext_clk, read by nothing; the pwm phase is phase_r
  always_ff @(posedge pwm_ext_clk) begin
    if (sys_rst) begin
      ext_cfg_s1_r <= 3'h0;
      ext_cfg_s2_r <= 3'h0;
      ext_phase_r <= 7'h00;
      ext_wrap_tgl_r <= 1'b0;
      ext_dom_sync_r <= 2'h0;
    end else begin
      ext_cfg_s1_r <= {pwm_en_eff, src_int, 1'b0};
      ext_cfg_s2_r <= ext_cfg_s1_r;
      ext_dom_sync_r <= {ext_dom_sync_r[0], ext_cfg_s2_r[2]};
      if (ext_cfg_s2_r[2]) begin
        ext_phase_r <= ext_phase_r + 7'h01;
        if (ext_phase_r == 7'h7f) begin
          ext_wrap_tgl_r <= ~ext_wrap_tgl_r;
        end
      end else begin
        ext_phase_r <= 7'h00;
      end
    end
  end

  // ----------------------------------------
  // pwm tick in sys domain: external edge or oscillator tick
  // ----------------------------------------
  logic [15:0] ext_per_cnt_r;
  logic clk_loss_r;
  logic [6:0] phase_r;  // shared pwm phase, counted in sys domain
  logic [6:0] edge_cnt_r [4];
  wire ext_rise = din_s[0] & ~pin_s3_r[0] & pin_s2_r[0];
  logic pin_stable_r_d0;  // previous synchronised first input, for edge detect
  // R10: selected clock source
  wire pwm_tick = src_int ? osc_tick : (din_s[0] & ~pin_stable_r_d0);

  // R14: external clock frequency monitor
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pin_stable_r_d0 <= 1'b0;
      ext_per_cnt_r <= 16'h0000;
      clk_loss_r <= 1'b0;
      phase_r <= 7'h00;
    end else if (clk_en) begin
      pin_stable_r_d0 <= din_s[0];
      if (din_s[0] & ~pin_stable_r_d0) begin
        clk_loss_r <= (ext_per_cnt_r < lspm_pkg::EXT_PER_MIN) | (ext_per_cnt_r > lspm_pkg::EXT_PER_MAX);
        ext_per_cnt_r <= 16'h0000;
      end else if (ext_per_cnt_r != 16'hffff) begin
        ext_per_cnt_r <= ext_per_cnt_r + 16'h0001;
        if (ext_per_cnt_r > lspm_pkg::EXT_PER_MAX) begin
          clk_loss_r <= 1'b1;
        end
      end
      if (!pwm_en_eff) begin
        phase_r <= 7'h00;
      end else if (pwm_tick) begin
        phase_r <= phase_r + 7'h01;
      end
    end
  end

  // R14: loss only matters while the external source is chosen
  wire pwm_run = pwm_en_eff & (src_int | ~clk_loss_r);

  // ----------------------------------------
  // per output delay, duty and command
  // ----------------------------------------
  logic [3:0] hs_r;
  logic [3:0] rearm_r;
  logic [3:0] duty_wave;
  logic [3:0] on_cmd;

  generate
    for (gi = 0; gi < 4; gi++) begin : g_out
      wire [6:0] duty = duty_codes[gi*7 +: 7];
      // R13: delay of 16 times code in pwm clocks
      wire [6:0] dly = {delay_codes[gi*3 +: 3], 4'h0};
      wire [6:0] ph = phase_r - dly;
      // R11: high for (n+1) of 128 steps, full code always on
      assign duty_wave[gi] = (duty == lspm_pkg::DUTY_FULL) | (ph <= duty);
      // R8: normal command; R12: direct input ignored under pwm
      assign on_cmd[gi] = pwm_en_eff ? (on_eff[gi] & (pwm_run ? duty_wave[gi] : 1'b1))
                                     : ((din_s[gi] & ~blk_eff[gi]) | on_eff[gi]);
      // R9: rearm term, toggle clears latched faults downstream
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          rearm_r[gi] <= 1'b0;
        end else if (clk_en) begin
          rearm_r[gi] <= ((in_active_r[gi] & ~blk_eff[gi] & ~pwm_en_eff) | on_eff[gi]) & (normal_m | fsafe_m);
        end
      end
    end
  endgenerate

  // output registers and mode
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      // R6: sleep after power up
      mode_r <= lspm_pkg::LSPM_SLEEP;
      hs_r <= 4'h0;
      fault_clear <= 4'h0;
    end else if (clk_en) begin
      mode_r <= mode_nxt;
      // R19: entering or leaving fail-safe clears latched faults
      fault_clear <= {4{(mode_nxt == lspm_pkg::LSPM_FSAFE) != fsafe_m}};
      case (mode_r)
        // R4: sleep keeps all outputs off
        lspm_pkg::LSPM_SLEEP: hs_r <= 4'h0;
        lspm_pkg::LSPM_NORMAL: hs_r <= on_cmd;
        // R20: fail-safe outputs follow direct inputs
        lspm_pkg::LSPM_FSAFE: hs_r <= din_s;
        // R5: faulted outputs held off, others keep command, or direct inputs under fail
        lspm_pkg::LSPM_FAULT: hs_r <= (fail ? din_s : on_cmd) & ~out_fault;
        default: hs_r <= 4'h0;
      endcase
    end
  end

  // R7: indicator one only in normal
  logic nm_r;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      nm_r <= 1'b0;
    end else if (clk_en) begin
      nm_r <= (mode_nxt == lspm_pkg::LSPM_NORMAL);
    end
  end

  // R14: flag reads one while external clock lost and pwm runs on the external source
  logic loss_flag_r;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      loss_flag_r <= 1'b0;
    end else if (clk_en) begin
      loss_flag_r <= clk_loss_r & pwm_en_eff & ~src_int;
    end
  end

  assign high_side_output = hs_r;
  assign fault_rearm_command = rearm_r;
  assign normal_mode_indicator = nm_r;
  assign external_clock_loss_flag = loss_flag_r;
  assign mode_state = mode_r;
  assign osc_half_period = osc_half_r;

endmodule : lspm_ctrl

/* File: design/lspm_pkg.sv */
// lspm_pkg: shared constants for the lamp switch mode and pwm controller
package lspm_pkg;
  // ----------------------------------------
  // sizing
  // ----------------------------------------
  localparam int unsigned NUM_OUT = 4;
  localparam int unsigned DUTY_W = 7;
  localparam int unsigned DLY_W = 3;
  localparam int unsigned PWM_STEPS = 128;
  localparam logic [6:0] DUTY_FULL = 7'h7f;
  localparam int unsigned DLY_UNIT = 16;
  // ----------------------------------------
  // timing, system clock 25 mhz
  // ----------------------------------------
  localparam int unsigned SYS_CLK_HZ = 25000000;
  localparam int unsigned QUAL_TIME_NS = 400;
  localparam int unsigned QUAL_CYC = (QUAL_TIME_NS * (SYS_CLK_HZ / 1000000) + 999) / 1000;
  // default internal oscillator half period in sys cycles (plain default)
  localparam logic [15:0] OSC_HALF_DEF = 16'h0028;
  // calibration pulse window in sys cycles
  localparam logic [23:0] CAL_MIN_CYC = 24'h000100;
  localparam logic [23:0] CAL_MAX_CYC = 24'h7fffff;
  // watchdog timeout in internal oscillator periods
  localparam logic [15:0] WDOG_OSC_PER = 16'h0400;
  // external clock monitor: allowed sys cycles between in0 rising edges
  localparam logic [15:0] EXT_PER_MIN = 16'h0004;
  localparam logic [15:0] EXT_PER_MAX = 16'h0fff;
  // ----------------------------------------
  // modes, one-hot
  // ----------------------------------------
  typedef enum logic [3:0] {
    LSPM_SLEEP = 4'h1,
    LSPM_NORMAL = 4'h2,
    LSPM_FSAFE = 4'h4,
    LSPM_FAULT = 4'h8
  } lspm_mode_t;
endpackage : lspm_pkg

/* File: dv/lspm_checker.sv */
// lspm_checker: port assertions for the mode and pwm controller
`timescale 1ns/10ps
module lspm_checker (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic reset_bar_pin,
  input wire logic rouse_pin,
  input wire logic [3:0] direct_in,
  input wire logic [3:0] thermal_flags,
  input wire logic [3:0] on_bits,
  input wire logic pulse_module_enable,
  input wire logic [11:0] delay_codes,
  input wire logic chip_sel_n,
  input wire logic [3:0] high_side_output,
  input wire logic [3:0] fault_clear,
  input wire logic normal_mode_indicator,
  input wire logic [3:0] mode_state,
  input wire logic [15:0] osc_half_period
);
  // ---
  // single domain, reset once
  // ---
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  property p_onehot;
    $onehot(mode_state);
  endproperty
  a_onehot: assert property (p_onehot) else $error("mode not one-hot");
  // two cycles so a registered lag is allowed
  property p_sleep_off;
    (mode_state == 4'h1) [*2] |-> high_side_output == 4'h0;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("output on in sleep");
  // eight cycles covers the pin synchronisers
  property p_sleep_in;
    (!reset_bar_pin && !rouse_pin && direct_in == 4'h0) [*8] |-> mode_state == 4'h1;
  endproperty
  a_sleep_in: assert property (p_sleep_in) else $error("no sleep without wake");
  property p_nm_on;
    (mode_state == 4'h2) [*2] |-> normal_mode_indicator;
  endproperty
  a_nm_on: assert property (p_nm_on) else $error("indicator low in normal");
  property p_nm_off;
    (mode_state == 4'h4) [*2] |-> !normal_mode_indicator;
  endproperty
  a_nm_off: assert property (p_nm_off) else $error("indicator high in fail-safe");
  property p_fault;
    (reset_bar_pin && thermal_flags != 4'h0) [*8] |-> mode_state == 4'h8;
  endproperty
  a_fault: assert property (p_fault) else $error("thermal flag gave no fault");
  // delay code zero keeps the check free of the stagger
  property p_pwm_off;
    (mode_state == 4'h2 && pulse_module_enable && !on_bits[3] && delay_codes[11:9] == 3'h0) [*4]
      |-> !high_side_output[3];
  endproperty
  a_pwm_off: assert property (p_pwm_off) else $error("output on with on bit clear");
  property p_fclr_in;
    mode_state == 4'h4 && $past(mode_state) == 4'h2 |-> ##[0:1] fault_clear == 4'hf;
  endproperty
  a_fclr_in: assert property (p_fclr_in) else $error("no clear on fail-safe entry");
  property p_fclr_one;
    fault_clear != 4'h0 |=> fault_clear == 4'h0;
  endproperty
  a_fclr_one: assert property (p_fclr_one) else $error("clear pulse too long");
  // trim only lands after the pulse ends
  property p_osc_hold;
    (chip_sel_n == 1'b0) [*4] |-> $stable(osc_half_period);
  endproperty
  a_osc_hold: assert property (p_osc_hold) else $error("trim moved while pulse low");
endmodule : lspm_checker

/* File: dv/lspm_host.sv */
// lspm_host: host model, watchdog words and calibration pulse
`timescale 1ns/10ps
module lspm_host (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic kick_en,
  input wire logic resume_go,
  input wire logic cal_go,
  input wire logic [23:0] cal_len,
  output logic chip_sel_n = 1'b1,
  output logic cal_arm = 1'b0,
  output logic spi_word_strobe = 1'b0,
  output logic watchdog_toggle_bit = 1'b0,
  output logic watchdog_input_bit = 1'b0
);
  logic [7:0] gap_r = 8'h00; // spacing of words
  logic [24:0] left_r = 25'h0000000; // cycles left in cal run
  // ---
  // words and calibration
  // ---
  always @(posedge sys_clk) begin
    gap_r <= gap_r + 8'h01;
    spi_word_strobe <= 1'b0;
    cal_arm <= 1'b0;
    if (!sys_rst && ((kick_en && gap_r == 8'h00) || resume_go)) begin
      spi_word_strobe <= 1'b1;
      watchdog_toggle_bit <= ~watchdog_toggle_bit;
      watchdog_input_bit <= resume_go;
    end
    if (cal_go) begin
      cal_arm <= 1'b1;
      left_r <= {1'b0, cal_len} + 25'h0000010;
    end else if (left_r != 25'h0000000) begin
      left_r <= left_r - 25'h0000001;
      if (left_r == {1'b0, cal_len} + 25'h0000001)
        chip_sel_n <= 1'b0;
      if (left_r == 25'h0000001)
        chip_sel_n <= 1'b1;
    end
  end
endmodule : lspm_host

/* File: dv/tb_top.sv */
// tb_top: self-checking bench for the mode and pwm controller
`timescale 1ns/10ps
`define CMP(n, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_top;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic pwm_ext_clk = 1'b0;
  logic rbar = 1'b0, rouse = 1'b0, fsel = 1'b1, lsf = 1'b0, lse = 1'b0, pme = 1'b0, src = 1'b0;
  logic low_f = 1'b0, exc_f = 1'b0, exc_off = 1'b0, kick = 1'b0, resume = 1'b0, cal_go = 1'b0, meas, ce = 1'b1;
  logic [3:0] din = 4'h0, onb = 4'h0, blk = 4'h0, lim_f = 4'h0, hot_f = 4'h0, shr_f = 4'h0;
  logic [27:0] duty = 28'h0000000;
  logic [11:0] dly = 12'h000;
  logic [23:0] cal_len = 24'h000000;
  logic csn, carm, stb, tgl, wib, nmi, lossf;
  logic [3:0] hso, rearm, fclr, mode;
  logic [15:0] osc;
  logic [31:0] seed = 32'hf4c3;
  logic [19:0] q[$]; // notes: select, expected
  logic [19:0] ent;
  int bad_count = 0, n_checks = 0, cyc = 0;
  int cnt[5];
  int pexp[5] = '{2560, 1280, 1920, 0, 640}; // high cycles in ten periods, last is overlap
  string nm[8] = '{"mode", "hso", "nmi", "osc", "loss", "pwm", "rearm", "hso2"};
  event chk_ev;
  always #20 sys_clk = ~sys_clk;
  always #7.5 pwm_ext_clk = ~pwm_ext_clk;
  lspm_ctrl uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(ce), .pwm_ext_clk(pwm_ext_clk),
    .direct_in(din), .reset_bar_pin(rbar), .rouse_pin(rouse), .failsafe_select_pin(fsel),
    .chip_sel_n(csn), .logic_supply_fail(lsf), .logic_supply_loss_enable(lse),
    .current_limit_flags(lim_f), .thermal_flags(hot_f), .hard_short_flags(shr_f),
    .supply_low_flag(low_f), .supply_excess_flag(exc_f), .supply_excess_shutdown_off(exc_off),
    .on_bits(onb), .duty_codes(duty), .delay_codes(dly), .parallel_input_block(blk),
    .pulse_module_enable(pme), .pwm_clock_source_choice(src), .cal_arm(carm),
    .spi_word_strobe(stb), .watchdog_toggle_bit(tgl), .watchdog_input_bit(wib),
    .high_side_output(hso), .fault_rearm_command(rearm), .fault_clear(fclr),
    .normal_mode_indicator(nmi), .external_clock_loss_flag(lossf), .mode_state(mode),
    .osc_half_period(osc));
  lspm_host host (.sys_clk(sys_clk), .sys_rst(sys_rst), .kick_en(kick), .resume_go(resume),
    .cal_go(cal_go), .cal_len(cal_len), .chip_sel_n(csn), .cal_arm(carm), .spi_word_strobe(stb),
    .watchdog_toggle_bit(tgl), .watchdog_input_bit(wib));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [15:0] obs(input logic [3:0] s);
    case (s)
      4'h0: return {12'h000, mode};
      4'h1: return {12'h000, hso};
      4'h2: return {15'h0000, nmi};
      4'h3: return osc;
      4'h4: return {15'h0000, lossf};
      4'h5: return {15'h0000, meas};
      4'h6: return {12'h000, rearm};
      default: return {15'h0000, hso[2]};
    endcase
  endfunction : obs
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wt
  // sample off the edge, hand back on an edge
  task automatic note(input logic [3:0] s, input logic [15:0] e);
    #1;
    q.push_back({s, e});
    -> chk_ev;
    @(posedge sys_clk);
  endtask : note
  task automatic cal(input logic [23:0] n);
    cal_len <= n;
    cal_go <= 1'b1;
    wt(1);
    cal_go <= 1'b0;
    wt(int'(n) + 64);
  endtask : cal
  task automatic resume_word;
    resume <= 1'b1;
    wt(1);
    resume <= 1'b0;
    wt(20);
  endtask : resume_word
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  // ---
  // monitor: oldest note against the outputs
  // ---
  always begin
    @(chk_ev);
    ent = q.pop_front();
    `CMP(nm[ent[19:16]], ent[15:0], obs(ent[19:16]))
  end
  // hang guard, well above the planned run
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      test_done();
    end
  end
  // ---
  // main sequence
  // ---
  initial begin
    wt(6);
    sys_rst <= 1'b0;
    wt(2);
    note(4'h0, 16'h0001);
    note(4'h3, 16'h0028);
    rbar <= 1'b1;
    kick <= 1'b1;
    wt(20);
    note(4'h0, 16'h0002);
    note(4'h2, 16'h0001);
    // enable low freezes the outputs while the inputs move
    ce <= 1'b0;
    din <= 4'hf;
    wt(30);
    note(4'h1, 16'h0000);
    ce <= 1'b1;
    repeat (4) begin
      seed = lfsr(seed);
      din <= seed[3:0];
      blk <= seed[7:4];
      onb <= seed[11:8];
      wt(30);
      note(4'h1, {12'h000, (din & ~blk) | onb});
      note(4'h6, {12'h000, (din & ~blk) | onb});
    end
    onb <= 4'hf;
    din <= 4'h0;
    for (int k = 0; k < 6; k++) begin
      lim_f <= (k == 0) ? 4'h4 : 4'h0;
      hot_f <= (k == 1) ? 4'h4 : 4'h0;
      shr_f <= (k == 2) ? 4'h4 : 4'h0;
      low_f <= (k == 3);
      exc_f <= (k > 3);
      exc_off <= (k == 5);
      wt(20);
      note(4'h0, (k == 5) ? 16'h0002 : 16'h0008);
      if (k < 3)
        note(4'h7, 16'h0000);
      {lim_f, hot_f, shr_f, low_f, exc_f} <= '0;
      wt(20);
      note(4'h0, 16'h0002);
    end
    cal(24'h000180);
    note(4'h3, 16'h0001);
    cal(24'h000040);
    note(4'h3, 16'h0001);
    onb <= 4'h7;
    duty <= {7'h00, 7'h5f, 7'h3f, 7'h7f};
    // output one delayed by 64 steps
    dly <= 12'h020;
    src <= 1'b1;
    pme <= 1'b1;
    wt(600);
    cnt = '{0, 0, 0, 0, 0};
    for (int k = 0; k < 2560; k++) begin
      if (k % 64 == 0) begin
        seed = lfsr(seed);
        din <= {seed[2:0], 1'b0};
      end
      wt(1);
      for (int i = 0; i < 4; i++)
        cnt[i] += int'(hso[i]);
      // delayed output one overlaps output two by 32 steps only
      cnt[4] += int'(hso[1] & hso[2]);
    end
    meas = 1'b1;
    foreach (cnt[i])
      if (cnt[i] > pexp[i] + 40 || cnt[i] + 40 < pexp[i])
        meas = 1'b0;
    note(4'h5, 16'h0001);
    src <= 1'b0;
    din <= 4'h0;
    wt(4600);
    note(4'h4, 16'h0001);
    note(4'h1, 16'h0007);
    repeat (80) begin
      din[0] <= ~din[0];
      wt(8);
    end
    note(4'h4, 16'h0000);
    pme <= 1'b0;
    onb <= 4'h0;
    kick <= 1'b0;
    din <= 4'h5;
    wt(3000);
    note(4'h0, 16'h0004);
    note(4'h2, 16'h0000);
    note(4'h1, 16'h0005);
    kick <= 1'b1;
    resume_word();
    note(4'h0, 16'h0002);
    cal(24'h000180);
    kick <= 1'b0;
    din <= 4'ha;
    wt(3000);
    note(4'h0, 16'h0004);
    fsel <= 1'b0;
    wt(20);
    note(4'h0, 16'h0002);
    lse <= 1'b1;
    lsf <= 1'b1;
    wt(20);
    note(4'h0, 16'h0004);
    lsf <= 1'b0;
    wt(20);
    note(4'h0, 16'h0004);
    resume_word();
    note(4'h0, 16'h0002);
    rbar <= 1'b0;
    din <= 4'h0;
    lse <= 1'b0;
    wt(30);
    note(4'h0, 16'h0001);
    note(4'h1, 16'h0000);
    rouse <= 1'b1;
    wt(20);
    note(4'h0, 16'h0002);
    test_done();
  end
endmodule : tb_top
bind lspm_ctrl lspm_checker chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .reset_bar_pin(reset_bar_pin),
  .rouse_pin(rouse_pin), .direct_in(direct_in), .thermal_flags(thermal_flags), .on_bits(on_bits),
  .pulse_module_enable(pulse_module_enable), .delay_codes(delay_codes), .chip_sel_n(chip_sel_n),
  .high_side_output(high_side_output), .fault_clear(fault_clear),
  .normal_mode_indicator(normal_mode_indicator), .mode_state(mode_state),
  .osc_half_period(osc_half_period));
